//--- hdl/mff_pkg.sv
// Purpose: Shared constants for the MAC flow, back-off and filter control block
// Assumes: 250 MHz system clock, link timing counted in nibble (4-bit) times
// Notes:   Register offsets are byte addresses on the 8-bit register port
package mff_pkg;
    localparam int unsigned CLK_NS         = 4;
    // Nibble times at each link speed
    localparam int unsigned NIBBLE_NS_100  = 40;
    localparam int unsigned NIBBLE_NS_10   = 400;
    localparam int unsigned NIB_CYC_100    = NIBBLE_NS_100 / CLK_NS;
    localparam int unsigned NIB_CYC_10     = NIBBLE_NS_10 / CLK_NS;
    // Bit-time figures converted to nibble times
    localparam int unsigned IPG_BITS       = 96;
    localparam int unsigned SLOT_BITS      = 512;
    localparam logic [7:0]  IPG_NIB        = 8'(IPG_BITS / 4);
    localparam logic [7:0]  SLOT_NIB       = 8'(SLOT_BITS / 4);
    localparam logic [4:0]  MAX_ATTEMPTS   = 5'h10;
    localparam logic [3:0]  BACKOFF_LIMIT  = 4'hA;
    // Backpressure carrier on time and silent gap, in nibbles
    localparam logic [15:0] BP_ON_NIB      = 16'h2000;
    localparam logic [15:0] BP_GAP_NIB     = 16'h0008;
    localparam logic [15:0] XOFF_TIME      = 16'hFFFF;
    localparam logic [15:0] XON_TIME       = 16'h0000;
    // Register map
    localparam logic [7:0]  LOW_WM_OFS     = 8'hB0;
    localparam logic [7:0]  HIGH_WM_OFS    = 8'hB2;
    localparam logic [7:0]  OVR_WM_OFS     = 8'hB4;
    localparam logic [15:0] LOW_WM_RST     = 16'h1400;
    localparam logic [15:0] HIGH_WM_RST    = 16'h0C00;
    localparam logic [15:0] OVR_WM_RST     = 16'h0100;
    // Destination filter schemes
    localparam logic [3:0]  FLT_ALL        = 4'h0;
    localparam logic [3:0]  FLT_PERFECT    = 4'h1;
    localparam logic [3:0]  FLT_INV_PERF   = 4'h2;
    localparam logic [3:0]  FLT_HASH       = 4'h3;
    localparam logic [3:0]  FLT_INV_HASH   = 4'h4;
    localparam logic [3:0]  FLT_PERF_ALLMC = 4'h5;
    localparam logic [3:0]  FLT_PERF_HASHM = 4'h6;
    localparam logic [3:0]  FLT_ALLU_HASHM = 4'h7;
    localparam logic [3:0]  FLT_PERF_NOMC  = 4'h8;
    localparam logic [3:0]  FLT_MC_ONLY    = 4'h9;
    localparam logic [3:0]  FLT_PERF_BCAST = 4'hA;
    typedef enum {TX_IDLE, TX_IPG, TX_XMIT, TX_BACKOFF, TX_BP_ON, TX_BP_GAP} mff_tx_type;
endpackage : mff_pkg

//--- hdl/mff_mac_flow_filter.sv
// Purpose: MAC transmit timing, pause flow control, backpressure and DA filtering
// Assumes: Datapath sends frames on tx_start and reports their end on tx_frame_end
// Notes:   All link timing counts whole nibble times of the selected speed
// Behaviour
// - After a good frame, keep at least 96 bit times idle before next.
// - After collisions, time the 96-bit gap from carrier sense dropping.
// - Half duplex uses binary exponential back-off; drop after 16 collisions.
// - Collision later than 512 bit times into a frame drops it, no retry.
// - Received pause withholds the next normal frame until pause timer expires.
// - A new pause frame while timing reloads the timer with its value.
// - While paused only our own flow control frames are sent.
// - Start pausing when free queue space falls to high watermark.
// - Stop pausing when free space recovers to low watermark, giving hysteresis.
// - Drop incoming frames when free space falls to the overrun watermark.
// - Flow control on sends a pause frame with maximum pause time.
// - When resources free up, send pause frame with zero pause time.
// - Half-duplex backpressure uses same watermarks and sends preamble as carrier.
// - Long backpressure drops carrier briefly then raises it again quickly.
// - Own queued frames interrupt backpressure, which resumes afterwards.
// - Collision during backpressure skips back-off and regenerates carrier at once.
// - Eleven selectable destination-address filtering schemes are offered.
// - Destination address compared with station address or 64-bit hash table.
// - First transmitted DA bit, bit 40, zero means individual, one multicast.
// - With the own-source drop bit set, frames with our source address drop.
`timescale 1ns/1ns
module mff_mac_flow_filter #(
    parameter int unsigned LFSR_SEED = 16'hACE1
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Configuration
    input  wire logic        full_duplex,
    input  wire logic        speed_100,
    input  wire logic        backpressure_en,
    input  wire logic [47:0] station_addr,
    input  wire logic [63:0] hash_table,
    input  wire logic [3:0]  filter_mode,
    input  wire logic        rx_enable,
    input  wire logic        rx_unicast_en,
    input  wire logic        rx_multicast_en,
    input  wire logic        rx_drop_own_sa,
    // PHY side
    input  wire logic        phy_crs,
    input  wire logic        phy_col,
    output logic             phy_bp_carrier,
    // Transmit queue and datapath
    input  wire logic        tx_frame_req,
    input  wire logic        tx_frame_end,
    output logic             tx_start,
    output logic             tx_is_pause,
    output logic      [15:0] tx_pause_time,
    output logic             tx_abort,
    output logic             tx_drop,
    output logic             tx_done_ok,
    // Receive side
    input  wire logic        rx_pause_valid,
    input  wire logic [15:0] rx_pause_quanta,
    input  wire logic [15:0] rxq_free_bytes,
    input  wire logic        rx_addr_valid,
    input  wire logic [47:0] rx_da,
    input  wire logic [47:0] rx_sa,
    output logic             rx_accept,
    output logic             rx_reject,
    output logic             rx_overrun_drop,
    // Status
    output logic             tx_paused,
    output logic             flow_active
);
    if (LFSR_SEED == 0 || LFSR_SEED > 16'hFFFF) begin : g_seed_chk
        $error("LFSR_SEED must be a nonzero 16-bit value");
    end

    function automatic logic [5:0] hash_index(input logic [47:0] da);
        logic [31:0] crc;
        logic        fb;
        crc = 32'hFFFFFFFF;
        // Bytes go out first byte first, each byte LSB first
        for (int b = 0; b < 6; b++) begin
            for (int i = 0; i < 8; i++) begin
                fb = crc[31] ^ da[47 - 8 * b - 7 + i];
                crc = {crc[30:0], 1'b0} ^ (fb ? 32'h04C11DB7 : 32'h00000000);
            end
        end
        return crc[31:26];
    endfunction : hash_index

    ////////////////////////////////////////////////////////////////////////////
    // Registers and nibble timebase
    logic [15:0] low_wm_reg, low_wm_next, high_wm_reg, high_wm_next;
    logic [15:0] ovr_wm_reg, ovr_wm_next, rdata_next;
    logic [6:0]  div_reg, div_next;
    logic        nib;

    assign nib = (div_reg == 7'h00);
    always_comb begin
        low_wm_next  = low_wm_reg;
        high_wm_next = high_wm_reg;
        ovr_wm_next  = ovr_wm_reg;
        if (reg_wr && reg_addr == mff_pkg::LOW_WM_OFS) low_wm_next = reg_wdata;
        if (reg_wr && reg_addr == mff_pkg::HIGH_WM_OFS) high_wm_next = reg_wdata;
        if (reg_wr && reg_addr == mff_pkg::OVR_WM_OFS) ovr_wm_next = reg_wdata;
        case (reg_addr)
            mff_pkg::LOW_WM_OFS:  rdata_next = low_wm_reg;
            mff_pkg::HIGH_WM_OFS: rdata_next = high_wm_reg;
            mff_pkg::OVR_WM_OFS:  rdata_next = ovr_wm_reg;
            default:              rdata_next = 16'h0000;
        endcase
        if (nib) begin
            div_next = speed_100 ? 7'(mff_pkg::NIB_CYC_100 - 1) : 7'(mff_pkg::NIB_CYC_10 - 1);
        end else begin
            div_next = div_reg - 7'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            low_wm_reg  <= mff_pkg::LOW_WM_RST;
            high_wm_reg <= mff_pkg::HIGH_WM_RST;
            ovr_wm_reg  <= mff_pkg::OVR_WM_RST;
            reg_rdata   <= 16'h0000;
            div_reg     <= 7'h00;
        end else begin
            low_wm_reg  <= low_wm_next;
            high_wm_reg <= high_wm_next;
            ovr_wm_reg  <= ovr_wm_next;
            reg_rdata   <= rdata_next;
            div_reg     <= div_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watermark flow control and received pause timer
    logic        flow_next, pend_reg, pend_next, ovr_next, tx_pause_start;
    logic [15:0] ptime_next, pq_reg, pq_next;
    logic [7:0]  psub_reg, psub_next;

    always_comb begin
        flow_next  = flow_active;
        pend_next  = pend_reg;
        ptime_next = tx_pause_time;
        if (tx_pause_start) pend_next = 1'b0;
        if (!flow_active && rxq_free_bytes <= high_wm_reg) begin
            flow_next  = 1'b1;
            pend_next  = full_duplex;
            ptime_next = mff_pkg::XOFF_TIME;
        end else if (flow_active && rxq_free_bytes >= low_wm_reg) begin
            flow_next  = 1'b0;
            pend_next  = full_duplex;
            ptime_next = mff_pkg::XON_TIME;
        end
        ovr_next = (rxq_free_bytes <= ovr_wm_reg);
        pq_next   = pq_reg;
        psub_next = psub_reg;
        if (rx_pause_valid && full_duplex) begin
            pq_next   = rx_pause_quanta;
            psub_next = mff_pkg::SLOT_NIB - 8'h01;
        end else if (nib && pq_reg != 16'h0000) begin
            if (psub_reg == 8'h00) begin
                psub_next = mff_pkg::SLOT_NIB - 8'h01;
                pq_next   = pq_reg - 16'h0001;
            end else begin
                psub_next = psub_reg - 8'h01;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flow_active     <= 1'b0;
            pend_reg        <= 1'b0;
            tx_pause_time   <= mff_pkg::XON_TIME;
            rx_overrun_drop <= 1'b0;
            pq_reg          <= 16'h0000;
            psub_reg        <= 8'h00;
        end else begin
            flow_active     <= flow_next;
            pend_reg        <= pend_next;
            tx_pause_time   <= ptime_next;
            rx_overrun_drop <= ovr_next;
            pq_reg          <= pq_next;
            psub_reg        <= psub_next;
        end
    end
    assign tx_paused = (pq_reg != 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // Transmit timing: gap, collisions, back-off, backpressure carrier
    mff_pkg::mff_tx_type st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next, lfsr_reg, lfsr_next;
    logic [9:0]  slots_reg, slots_next, mask;
    logic [7:0]  sub_reg, sub_next;
    logic [4:0]  ncol_reg, ncol_next;
    logic        coll_reg, coll_next, pause_reg, pause_next, bp_want;
    logic        start_n, abort_n, drop_n, ok_n, carrier_n;

    assign bp_want = flow_active && !full_duplex && backpressure_en;
    assign tx_pause_start = start_n && pend_reg;
    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        sub_next   = sub_reg;
        slots_next = slots_reg;
        ncol_next  = ncol_reg;
        coll_next  = coll_reg;
        pause_next = pause_reg;
        lfsr_next  = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        mask       = 10'(({1'b0, 10'h3FF} >> (4'hA - ((ncol_reg >= 5'(mff_pkg::BACKOFF_LIMIT))
                     ? mff_pkg::BACKOFF_LIMIT : ncol_reg[3:0] + 4'h1))));
        start_n    = 1'b0;
        abort_n    = 1'b0;
        drop_n     = 1'b0;
        ok_n       = 1'b0;
        carrier_n  = 1'b0;
        case (st_reg)
            mff_pkg::TX_IDLE: begin
                if (pend_reg || (tx_frame_req && !tx_paused)) begin
                    st_next  = mff_pkg::TX_IPG;
                    cnt_next = 16'h0000;
                end else if (bp_want) begin
                    st_next  = mff_pkg::TX_BP_ON;
                    cnt_next = 16'h0000;
                end
            end
            mff_pkg::TX_IPG: begin
                if (coll_reg && phy_crs && !full_duplex) begin
                    cnt_next = 16'h0000;
                end else if (nib) begin
                    cnt_next = cnt_reg + 16'h0001;
                end
                if (cnt_reg >= 16'(mff_pkg::IPG_NIB)) begin
                    if (pend_reg || (tx_frame_req && !tx_paused)) begin
                        start_n    = 1'b1;
                        pause_next = pend_reg;
                        st_next    = mff_pkg::TX_XMIT;
                        cnt_next   = 16'h0000;
                    end else begin
                        st_next = mff_pkg::TX_IDLE;
                    end
                end
            end
            mff_pkg::TX_XMIT: begin
                if (nib && cnt_reg != 16'hFFFF) cnt_next = cnt_reg + 16'h0001;
                if (phy_col && !full_duplex) begin
                    abort_n   = 1'b1;
                    coll_next = 1'b1;
                    ncol_next = ncol_reg + 5'h01;
                    lfsr_next = lfsr_reg;
                    if (cnt_reg > 16'(mff_pkg::SLOT_NIB)) begin
                        drop_n    = 1'b1;
                        ncol_next = 5'h00;
                        st_next   = bp_want ? mff_pkg::TX_BP_ON : mff_pkg::TX_IPG;
                    end else if (ncol_reg + 5'h01 >= mff_pkg::MAX_ATTEMPTS) begin
                        drop_n    = 1'b1;
                        ncol_next = 5'h00;
                        st_next   = bp_want ? mff_pkg::TX_BP_ON : mff_pkg::TX_IPG;
                    end else if (bp_want) begin
                        st_next = mff_pkg::TX_BP_ON;
                    end else begin
                        st_next    = mff_pkg::TX_BACKOFF;
                        slots_next = lfsr_reg[9:0] & mask;
                        sub_next   = mff_pkg::SLOT_NIB - 8'h01;
                    end
                    cnt_next = 16'h0000;
                end else if (tx_frame_end) begin
                    ok_n      = 1'b1;
                    ncol_next = 5'h00;
                    coll_next = 1'b0;
                    cnt_next  = 16'h0000;
                    st_next   = bp_want ? mff_pkg::TX_BP_ON : mff_pkg::TX_IPG;
                end
            end
            mff_pkg::TX_BACKOFF: begin
                if (slots_reg == 10'h000) begin
                    st_next  = mff_pkg::TX_IPG;
                    cnt_next = 16'h0000;
                end else if (nib) begin
                    if (sub_reg == 8'h00) begin
                        sub_next   = mff_pkg::SLOT_NIB - 8'h01;
                        slots_next = slots_reg - 10'h001;
                    end else begin
                        sub_next = sub_reg - 8'h01;
                    end
                end
            end
            mff_pkg::TX_BP_ON: begin
                carrier_n = 1'b1;
                if (nib) cnt_next = cnt_reg + 16'h0001;
                if (!bp_want || tx_frame_req || pend_reg) begin
                    st_next   = mff_pkg::TX_IPG;
                    coll_next = 1'b0;
                    cnt_next  = 16'h0000;
                end else if (cnt_reg >= mff_pkg::BP_ON_NIB && !phy_col) begin
                    st_next  = mff_pkg::TX_BP_GAP;
                    cnt_next = 16'h0000;
                end
            end
            mff_pkg::TX_BP_GAP: begin
                if (nib) cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg >= mff_pkg::BP_GAP_NIB) begin
                    st_next  = bp_want ? mff_pkg::TX_BP_ON : mff_pkg::TX_IDLE;
                    cnt_next = 16'h0000;
                end
            end
            default: st_next = mff_pkg::TX_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg         <= mff_pkg::TX_IDLE;
            cnt_reg        <= 16'h0000;
            sub_reg        <= 8'h00;
            slots_reg      <= 10'h000;
            ncol_reg       <= 5'h00;
            coll_reg       <= 1'b0;
            pause_reg      <= 1'b0;
            lfsr_reg       <= 16'(LFSR_SEED);
            tx_start       <= 1'b0;
            tx_abort       <= 1'b0;
            tx_drop        <= 1'b0;
            tx_done_ok     <= 1'b0;
            phy_bp_carrier <= 1'b0;
        end else begin
            st_reg         <= st_next;
            cnt_reg        <= cnt_next;
            sub_reg        <= sub_next;
            slots_reg      <= slots_next;
            ncol_reg       <= ncol_next;
            coll_reg       <= coll_next;
            pause_reg      <= pause_next;
            lfsr_reg       <= lfsr_next;
            tx_start       <= start_n;
            tx_abort       <= abort_n;
            tx_drop        <= drop_n;
            tx_done_ok     <= ok_n;
            phy_bp_carrier <= carrier_n;
        end
    end
    assign tx_is_pause = pause_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Destination address filter
    logic acc_n, rej_n, mcast, perf, hsh, bcast, pass;

    always_comb begin
        mcast = rx_da[40];
        bcast = (rx_da == 48'hFFFFFFFFFFFF);
        perf  = (rx_da == station_addr);
        hsh   = hash_table[hash_index(rx_da)];
        case (filter_mode)
            mff_pkg::FLT_ALL:        pass = 1'b1;
            mff_pkg::FLT_PERFECT:    pass = perf;
            mff_pkg::FLT_INV_PERF:   pass = !perf;
            mff_pkg::FLT_HASH:       pass = hsh;
            mff_pkg::FLT_INV_HASH:   pass = !hsh;
            mff_pkg::FLT_PERF_ALLMC: pass = mcast || perf;
            mff_pkg::FLT_PERF_HASHM: pass = mcast ? hsh : perf;
            mff_pkg::FLT_ALLU_HASHM: pass = mcast ? hsh : 1'b1;
            mff_pkg::FLT_PERF_NOMC:  pass = !mcast && perf;
            mff_pkg::FLT_MC_ONLY:    pass = mcast;
            mff_pkg::FLT_PERF_BCAST: pass = bcast || perf;
            default:                 pass = 1'b0;
        endcase
        // Software-owned enables gate every scheme
        pass = pass && rx_enable && (mcast ? rx_multicast_en : rx_unicast_en);
        if (rx_drop_own_sa && rx_sa == station_addr) pass = 1'b0;
        if (rx_overrun_drop) pass = 1'b0;
        acc_n = rx_addr_valid && pass;
        rej_n = rx_addr_valid && !pass;
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_accept <= 1'b0;
            rx_reject <= 1'b0;
        end else begin
            rx_accept <= acc_n;
            rx_reject <= rej_n;
        end
    end
endmodule : mff_mac_flow_filter

//--- verification/mff_assertions.sv
// Purpose: Port-level checks for the MAC flow, back-off and filter block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   The paused-send check uses the cycle before a start, when the send was decided
`timescale 1ns/1ns
module mff_checker (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // Watched ports
    input wire logic        full_duplex,
    input wire logic        rx_drop_own_sa,
    input wire logic [47:0] station_addr,
    input wire logic        phy_col,
    input wire logic        tx_frame_end,
    input wire logic        tx_start,
    input wire logic        tx_is_pause,
    input wire logic        tx_abort,
    input wire logic        tx_drop,
    input wire logic        tx_done_ok,
    input wire logic        rx_pause_valid,
    input wire logic [15:0] rx_pause_quanta,
    input wire logic        rx_addr_valid,
    input wire logic [47:0] rx_sa,
    input wire logic        rx_accept,
    input wire logic        rx_reject,
    input wire logic        rx_overrun_drop,
    input wire logic        tx_paused
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    filter_answer_a: assert property (rx_addr_valid |=> rx_accept != rx_reject)
        else $error("Filter gave no single answer");
    own_source_a: assert property (rx_addr_valid && rx_drop_own_sa && rx_sa == station_addr
        |=> rx_reject) else $error("Own source frame kept");
    overrun_drop_a: assert property (rx_addr_valid && rx_overrun_drop |=> rx_reject)
        else $error("Frame kept during overrun");
    drop_abort_a: assert property (tx_drop |-> tx_abort)
        else $error("Drop without abort");
    abort_cause_a: assert property (tx_abort |-> $past(phy_col) && !$past(full_duplex))
        else $error("Abort without half duplex collision");
    done_cause_a: assert property (tx_done_ok |-> $past(tx_frame_end))
        else $error("Done without frame end");
    paused_send_a: assert property (tx_start && $past(tx_paused) |-> tx_is_pause)
        else $error("Normal frame sent while paused");
    pause_load_a: assert property (full_duplex && rx_pause_valid
        && rx_pause_quanta != 16'h0000 |=> tx_paused) else $error("Pause not loaded");
    cover property (tx_start && tx_is_pause);
    cover property (tx_drop);
    cover property (rx_accept && $past(rx_addr_valid));
endmodule : mff_checker
////////////////////////////////////////
bind mff_mac_flow_filter mff_checker u_chk (.sys_clk, .reset, .full_duplex, .rx_drop_own_sa,
    .station_addr, .phy_col, .tx_frame_end, .tx_start, .tx_is_pause, .tx_abort, .tx_drop,
    .tx_done_ok, .rx_pause_valid, .rx_pause_quanta, .rx_addr_valid, .rx_sa, .rx_accept,
    .rx_reject, .rx_overrun_drop, .tx_paused);

//--- verification/mff_partner.sv
// Purpose: Far station and datapath stand-in: carrier, collisions, frame end
// Assumes: Frames last 64 clocks unless a collision is commanded
// Notes:   A commanded collision drops carrier once the count reaches col_at plus 4, and no frame end follows it
`timescale 1ns/1ns
module mff_partner (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Frame activity and collision command
    input  wire logic        tx_start,
    input  wire logic [11:0] col_at,
    output logic             phy_crs,
    output logic             phy_col,
    output logic             tx_frame_end
);
    logic [11:0] cnt;
    logic        busy;
    always @(posedge sys_clk) begin
        tx_frame_end <= 1'b0;
        if (reset || (busy && col_at != 12'h000 && cnt == col_at + 12'h004)) begin
            busy    <= 1'b0;
            phy_crs <= 1'b0;
            phy_col <= 1'b0;
        end else if (tx_start) begin
            busy    <= 1'b1;
            cnt     <= 12'h001;
            phy_crs <= 1'b1;
        end else if (busy) begin
            cnt     <= cnt + 12'h001;
            phy_col <= col_at != 12'h000 && cnt >= col_at;
            if (col_at == 12'h000 && cnt == 12'h040) begin
                tx_frame_end <= 1'b1;
                busy         <= 1'b0;
                phy_crs      <= 1'b0;
            end
        end
    end
endmodule : mff_partner

//--- verification/mac_flow_filter_control_tb.sv
// Purpose: Self-checking bench for the MAC flow, back-off and filter block
// Assumes: 100M timing, ten clocks a nibble
// Notes:   Only the start of backpressure carrier is checked, not its long on and gap cycle
`timescale 1ns/1ns
module mac_flow_filter_control_tb;
    logic        sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, full_duplex = 1'b1;
    logic        speed_100 = 1'b1, backpressure_en = 1'b0, rx_enable = 1'b0;
    logic        rx_drop_own_sa = 1'b0, tx_frame_req = 1'b0, rx_pause_valid = 1'b0;
    logic        rx_addr_valid = 1'b0, rx_unicast_en, rx_multicast_en;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, rx_pause_quanta = 16'h0000, rxq_free_bytes = 16'h3000;
    logic [3:0]  filter_mode = 4'h0;
    logic [47:0] station_addr = 48'h021122334455, rx_da = 48'h021122334455;
    logic [47:0] rx_sa = 48'h0A0B0C0D0E0F;
    logic [63:0] hash_table = 64'hFFFFFFFFFFFFFFFF;
    logic [11:0] col_at = 12'h000;
    logic [15:0] reg_rdata, tx_pause_time;
    logic        phy_crs, phy_col, phy_bp_carrier, tx_frame_end, tx_start, tx_is_pause;
    logic        tx_abort, tx_drop, tx_done_ok, rx_accept, rx_reject, rx_overrun_drop;
    logic        tx_paused, flow_active;
    int          fails = 0, tests_run = 0;
    // Expected accept per scheme for our own unicast address
    localparam logic [10:0] FLT_EXP = 11'h5EB;
    assign rx_unicast_en = rx_enable;
    assign rx_multicast_en = rx_enable;
    always #2 sys_clk = ~sys_clk;
    mff_mac_flow_filter u_dut (.*);
    mff_partner u_far (.*);
    ////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_hi(ref logic s, input int lim);
        repeat (lim) begin
            if (s === 1'b1) break;
            @(posedge sys_clk);
            #1;
        end
        if (s !== 1'b1) begin
            fails++;
            tally_and_finish();
        end
    endtask : wait_hi
    task reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk) reg_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1 chk(reg_rdata, e);
    endtask : reg_read
    task flt(input logic [3:0] m, input logic e);
        @(posedge sys_clk);
        filter_mode   <= m;
        rx_addr_valid <= 1'b1;
        @(posedge sys_clk) rx_addr_valid <= 1'b0;
        #1 chk(16'({rx_accept, rx_reject}), 16'({e, ~e}));
    endtask : flt
    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk);
        reset     <= 1'b0;
        rx_enable <= 1'b1;
        reg_read(8'hB0, 16'h1400);
        reg_read(8'hB2, 16'h0C00);
        reg_read(8'hB4, 16'h0100);
        reg_write(8'h40, 16'h5A5A);
        reg_read(8'h40, 16'h0000);
        reg_write(8'hB4, 16'h0200);
        reg_read(8'hB4, 16'h0200);
        reg_write(8'hB4, 16'h0100);
        for (int m = 0; m < 11; m++) flt(4'(m), FLT_EXP[m]);
        @(posedge sys_clk) rx_da[40] <= 1'b1;
        flt(4'h8, 1'b0);
        flt(4'h9, 1'b1);
        @(posedge sys_clk);
        rx_sa          <= station_addr;
        rx_drop_own_sa <= 1'b1;
        flt(4'h0, 1'b0);
        @(posedge sys_clk) rx_drop_own_sa <= 1'b0;
        @(posedge sys_clk) rxq_free_bytes <= 16'h0C00;
        wait_hi(tx_start, 400);
        chk(16'(tx_is_pause), 16'h0001);
        chk(tx_pause_time, 16'hFFFF);
        @(posedge sys_clk) rxq_free_bytes <= 16'h0100;
        repeat (3) @(posedge sys_clk);
        #1 chk(16'(rx_overrun_drop), 16'h0001);
        flt(4'h0, 1'b0);
        @(posedge sys_clk) rxq_free_bytes <= 16'h1000;
        repeat (400) @(posedge sys_clk);
        #1 chk(16'(flow_active), 16'h0001);
        @(posedge sys_clk) rxq_free_bytes <= 16'h1400;
        wait_hi(tx_start, 400);
        chk(tx_pause_time, 16'h0000);
        wait_hi(tx_done_ok, 200);
        @(posedge sys_clk);
        rx_pause_quanta <= 16'h0003;
        rx_pause_valid  <= 1'b1;
        @(posedge sys_clk) rx_pause_valid <= 1'b0;
        tx_frame_req <= 1'b1;
        repeat (100) @(posedge sys_clk);
        rx_pause_quanta <= 16'h0001;
        rx_pause_valid  <= 1'b1;
        @(posedge sys_clk) rx_pause_valid <= 1'b0;
        repeat (1200) @(posedge sys_clk);
        #1 chk(16'(tx_paused), 16'h0001);
        wait_hi(tx_start, 400);
        chk(16'(tx_is_pause), 16'h0000);
        wait_hi(tx_done_ok, 200);
        @(posedge sys_clk);
        full_duplex <= 1'b0;
        col_at      <= 12'h014;
        wait_hi(tx_start, 400);
        wait_hi(tx_abort, 100);
        chk(16'(tx_drop), 16'h0000);
        repeat (10) @(posedge sys_clk);
        col_at <= 12'h000;
        wait_hi(tx_start, 3000);
        wait_hi(tx_done_ok, 200);
        @(posedge sys_clk) col_at <= 12'h578;
        wait_hi(tx_start, 400);
        wait_hi(tx_abort, 1500);
        chk(16'(tx_drop), 16'h0001);
        @(posedge sys_clk) tx_frame_req <= 1'b0;
        repeat (10) @(posedge sys_clk);
        col_at          <= 12'h000;
        backpressure_en <= 1'b1;
        rxq_free_bytes  <= 16'h0C00;
        wait_hi(phy_bp_carrier, 400);
        chk(16'(phy_bp_carrier), 16'h0001);
        tally_and_finish();
    end
endmodule : mac_flow_filter_control_tb
